// [rtl/ptp_event_interrupt_status.sv]
// ptp trigger and time stamp event interrupt status with apb access
//
// Overview of operation
// - trigger done or error sets unit bit
// - trigger status OR drives host status bit 10
// - trigger bit clears on written one only
// - read-write enable bit per trigger unit
// - trigger enables OR drive host enable bit 10
// - delay egress stamp sets status bit 13
// - sync egress stamp sets status bit 12
// - capture unit ready sets unit bit
// - fourteen stamp bits OR to host bit 12
// - stamp bit clears on written one only
// - stamp enables at 13, 12, 11:0
// - stamp enables OR drive host enable bit 12
`timescale 1ns/100ps
module ptp_event_interrupt_status #(
  parameter int UNITS = 12
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [13:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [UNITS-1:0] TRIGGER_EVENT_IN,
  input wire logic [UNITS-1:0] CAPTURE_UNIT_READY_IN,
  input wire logic SYNC_STAMP_IN,
  input wire logic DELAY_STAMP_IN,
  output logic TRIGGER_HOST_IRQ_OUT,
  output logic TIMESTAMP_HOST_IRQ_OUT,
  output logic IRQ_OUT
);
  localparam int TSW = UNITS + 2;

  logic [UNITS-1:0] trig_enable_reg;
  logic [UNITS-1:0] trig_enable_next;
  logic [TSW-1:0] ts_enable_reg;
  logic [TSW-1:0] ts_enable_next;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_mask_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic slverr_reg;
  logic [UNITS-1:0] trig_status;
  logic [TSW-1:0] ts_status;
  logic [UNITS-1:0] trig_clear;
  logic [TSW-1:0] ts_clear;
  logic [TSW-1:0] ts_set;
  logic [1:0] irq_status;
  logic [1:0] irq_clear;
  logic [1:0] irq_set;
  logic [1:0] host_status;
  logic [1:0] host_enable;
  logic [1:0] host_irq;
  logic [1:0] host_irq_q;
  logic setup_phase;
  logic wr_take;
  logic rd_setup;
  logic [11:0] idx;
  logic hit_trig_st;
  logic hit_trig_en;
  logic hit_ts_st;
  logic hit_ts_en;
  logic hit_host_st;
  logic hit_host_en;
  logic hit_irq_st;
  logic hit_irq_mask;
  logic addr_hit;

  // map a host-register bit position into a 16-bit word
  function automatic logic [15:0] host_word(input logic [1:0] v);
    logic [15:0] w;
    w = 16'h0000;
    w[ptp_irq_pkg::HOST_TRIG_BIT] = v[0];
    w[ptp_irq_pkg::HOST_TS_BIT] = v[1];
    return w;
  endfunction

  // apb decode: index is byte address divided by four
  assign idx = PADDR_IN[13:2];
  assign hit_trig_st = idx == ptp_irq_pkg::TRIG_STATUS_IDX;
  assign hit_trig_en = idx == ptp_irq_pkg::TRIG_ENABLE_IDX;
  assign hit_ts_st = idx == ptp_irq_pkg::TS_STATUS_IDX;
  assign hit_ts_en = idx == ptp_irq_pkg::TS_ENABLE_IDX;
  assign hit_host_st = idx == ptp_irq_pkg::HOST_STATUS_IDX;
  assign hit_host_en = idx == ptp_irq_pkg::HOST_ENABLE_IDX;
  assign hit_irq_st = idx == ptp_irq_pkg::IRQ_STATUS_IDX;
  assign hit_irq_mask = idx == ptp_irq_pkg::IRQ_MASK_IDX;
  assign addr_hit = hit_trig_st | hit_trig_en | hit_ts_st | hit_ts_en |
    hit_host_st | hit_host_en | hit_irq_st | hit_irq_mask;
  // read data is registered in setup, so the slave answers with no wait state
  assign setup_phase = PSEL_IN & ~PENABLE_IN;
  assign rd_setup = setup_phase & ~PWRITE_IN;
  assign wr_take = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign PREADY_OUT = 1'b1;
  assign PRDATA_OUT = rdata_reg;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & slverr_reg;

  // write-one clear strobes for the sticky registers
  assign trig_clear = (wr_take & hit_trig_st) ? PWDATA_IN[UNITS-1:0] :
    '0;
  assign ts_clear = (wr_take & hit_ts_st) ? PWDATA_IN[TSW-1:0] : '0;
  assign irq_clear = (wr_take & hit_irq_st) ?
    {PWDATA_IN[ptp_irq_pkg::HOST_TS_BIT],
     PWDATA_IN[ptp_irq_pkg::HOST_TRIG_BIT]} : 2'h0;

  // time stamp events: egress delay, egress sync, then unit ready bits
  assign ts_set = {DELAY_STAMP_IN, SYNC_STAMP_IN, CAPTURE_UNIT_READY_IN};

  // trigger status bits, independent of enables
  w1c_status #(.WIDTH(UNITS)) trig_status_u (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .set_in(TRIGGER_EVENT_IN),
    .clear_in(trig_clear),
    .status_out(trig_status)
  );

  // time stamp status bits
  w1c_status #(.WIDTH(TSW)) ts_status_u (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .set_in(ts_set),
    .clear_in(ts_clear),
    .status_out(ts_status)
  );

  // group reductions into host status and enable bits
  assign host_status = {|ts_status, |trig_status};
  assign host_enable = {|ts_enable_reg, |trig_enable_reg};
  assign host_irq = host_status & host_enable;
  assign TRIGGER_HOST_IRQ_OUT = host_irq[0];
  assign TIMESTAMP_HOST_IRQ_OUT = host_irq[1];

  // rising edge of a group interrupt latches sticky block status
  assign irq_set = host_irq & ~host_irq_q;
  w1c_status #(.WIDTH(2)) irq_status_u (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .set_in(irq_set),
    .clear_in(irq_clear),
    .status_out(irq_status)
  );
  assign IRQ_OUT = |(irq_status & irq_mask_reg);

  // enable and mask next values
  assign trig_enable_next = (wr_take & hit_trig_en) ?
    PWDATA_IN[UNITS-1:0] : trig_enable_reg;
  assign ts_enable_next = (wr_take & hit_ts_en) ?
    PWDATA_IN[TSW-1:0] : ts_enable_reg;
  assign irq_mask_next = (wr_take & hit_irq_mask) ?
    {PWDATA_IN[ptp_irq_pkg::HOST_TS_BIT],
     PWDATA_IN[ptp_irq_pkg::HOST_TRIG_BIT]} : irq_mask_reg;

  // read mux; reserved bits read zero
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_setup) begin
      rdata_next = 32'h0000_0000;
      if (hit_trig_st) rdata_next[UNITS-1:0] = trig_status;
      if (hit_trig_en) rdata_next[UNITS-1:0] = trig_enable_reg;
      if (hit_ts_st) rdata_next[TSW-1:0] = ts_status;
      if (hit_ts_en) rdata_next[TSW-1:0] = ts_enable_reg;
      if (hit_host_st) rdata_next[15:0] = host_word(host_status);
      if (hit_host_en) rdata_next[15:0] = host_word(host_enable);
      if (hit_irq_st) rdata_next[15:0] = host_word(irq_status);
      if (hit_irq_mask) rdata_next[15:0] = host_word(irq_mask_reg);
    end
  end

  // control registers
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      trig_enable_reg <= ptp_irq_pkg::ENABLE_RESET[UNITS-1:0];
      ts_enable_reg <= ptp_irq_pkg::ENABLE_RESET[TSW-1:0];
      irq_mask_reg <= ptp_irq_pkg::IRQ_RESET;
      host_irq_q <= ptp_irq_pkg::IRQ_RESET;
      rdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else begin
      trig_enable_reg <= trig_enable_next;
      ts_enable_reg <= ts_enable_next;
      irq_mask_reg <= irq_mask_next;
      host_irq_q <= host_irq;
      rdata_reg <= rdata_next;
      slverr_reg <= setup_phase ? ~addr_hit : slverr_reg;
    end
  end

  // checks
  property p_trig_set;
    @(posedge CLK_IN) disable iff (RST_IN)
      TRIGGER_EVENT_IN[0] |=> trig_status[0];
  endproperty
  a_trig_set: assert property (p_trig_set)
    else $error("trigger event did not set status");

  property p_host_trig;
    @(posedge CLK_IN) disable iff (RST_IN)
      host_status[0] == (trig_status != '0);
  endproperty
  a_host_trig: assert property (p_host_trig)
    else $error("host trigger status is not the or of bits");

  property p_w1c_trig;
    @(posedge CLK_IN) disable iff (RST_IN)
      (trig_status[0] && !TRIGGER_EVENT_IN[0] && !trig_clear[0])
        |=> trig_status[0];
  endproperty
  a_w1c_trig: assert property (p_w1c_trig)
    else $error("trigger status cleared without a written one");

  property p_trig_clr;
    @(posedge CLK_IN) disable iff (RST_IN)
      (trig_clear[0] && !TRIGGER_EVENT_IN[0]) |=> !trig_status[0];
  endproperty
  a_trig_clr: assert property (p_trig_clr)
    else $error("written one did not clear trigger status");

  property p_trig_en;
    @(posedge CLK_IN) disable iff (RST_IN)
      (wr_take && hit_trig_en) |=>
        trig_enable_reg == $past(PWDATA_IN[UNITS-1:0]);
  endproperty
  a_trig_en: assert property (p_trig_en)
    else $error("trigger enable write lost");

  property p_host_en;
    @(posedge CLK_IN) disable iff (RST_IN)
      host_enable == {ts_enable_reg != '0, trig_enable_reg != '0};
  endproperty
  a_host_en: assert property (p_host_en)
    else $error("host enable is not the or of enables");

  property p_delay_set;
    @(posedge CLK_IN) disable iff (RST_IN)
      DELAY_STAMP_IN |=> ts_status[TSW-1] && host_status[1];
  endproperty
  a_delay_set: assert property (p_delay_set)
    else $error("delay stamp did not set bit 13");

  property p_sync_set;
    @(posedge CLK_IN) disable iff (RST_IN)
      SYNC_STAMP_IN |=> ts_status[TSW-2] && host_status[1];
  endproperty
  a_sync_set: assert property (p_sync_set)
    else $error("sync stamp did not set bit 12");

  property p_ready_set;
    @(posedge CLK_IN) disable iff (RST_IN)
      CAPTURE_UNIT_READY_IN[UNITS-1] |=> ts_status[UNITS-1];
  endproperty
  a_ready_set: assert property (p_ready_set)
    else $error("capture ready did not set status");

  property p_ts_clr;
    @(posedge CLK_IN) disable iff (RST_IN)
      (ts_clear[TSW-1] && !DELAY_STAMP_IN && ts_status[0] &&
       !ts_clear[0]) |=> !ts_status[TSW-1] && ts_status[0];
  endproperty
  a_ts_clr: assert property (p_ts_clr)
    else $error("stamp clear wrong bit");

  property p_irq;
    @(posedge CLK_IN) disable iff (RST_IN)
      TIMESTAMP_HOST_IRQ_OUT == (host_status[1] && host_enable[1]);
  endproperty
  a_irq: assert property (p_irq)
    else $error("stamp interrupt disagrees with status and enable");

  property p_host_ts;
    @(posedge CLK_IN) disable iff (RST_IN)
      host_status[1] == (ts_status != '0);
  endproperty
  a_host_ts: assert property (p_host_ts)
    else $error("host stamp status is not the or of bits");

  property p_ts_en;
    @(posedge CLK_IN) disable iff (RST_IN)
      (wr_take && hit_ts_en) |=>
        ts_enable_reg == $past(PWDATA_IN[TSW-1:0]);
  endproperty
  a_ts_en: assert property (p_ts_en)
    else $error("stamp enable write lost");

  property p_trig_irq;
    @(posedge CLK_IN) disable iff (RST_IN)
      TRIGGER_HOST_IRQ_OUT == (host_status[0] && host_enable[0]);
  endproperty
  a_trig_irq: assert property (p_trig_irq)
    else $error("trigger interrupt disagrees with status and enable");

  c_trig_irq: cover property (@(posedge CLK_IN) TRIGGER_HOST_IRQ_OUT);
  c_ts_irq: cover property (@(posedge CLK_IN) TIMESTAMP_HOST_IRQ_OUT);
  c_set_clear: cover property (@(posedge CLK_IN)
    TRIGGER_EVENT_IN[0] && trig_clear[0]);
  c_out_irq: cover property (@(posedge CLK_IN) IRQ_OUT);
endmodule // ptp_event_interrupt_status

// [rtl/ptp_irq_pkg.sv]
// package: register map, field layout and reset values for ptp event irqs
package ptp_irq_pkg;
  // printed offsets are not all multiples of four: keep them as indices
  localparam logic [11:0] TRIG_STATUS_IDX = 12'h688;
  localparam logic [11:0] TRIG_ENABLE_IDX = 12'h68A;
  localparam logic [11:0] TS_STATUS_IDX = 12'h68C;
  localparam logic [11:0] TS_ENABLE_IDX = 12'h68E;
  localparam logic [11:0] HOST_STATUS_IDX = 12'h690;
  localparam logic [11:0] HOST_ENABLE_IDX = 12'h692;
  localparam logic [11:0] IRQ_STATUS_IDX = 12'h694;
  localparam logic [11:0] IRQ_MASK_IDX = 12'h696;
  localparam int UNIT_COUNT = 12;
  localparam int TS_SYNC_BIT = 12;
  localparam int TS_DELAY_BIT = 13;
  localparam int HOST_TRIG_BIT = 10;
  localparam int HOST_TS_BIT = 12;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [11:0] TRIG_MASK = 12'hFFF;
  localparam logic [13:0] TS_MASK = 14'h3FFF;
endpackage : ptp_irq_pkg

// [rtl/w1c_status.sv]
// sticky status bits: hardware set, software write-one clear, set wins
`timescale 1ns/100ps
module w1c_status #(
  parameter int WIDTH = 12
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clear_in,
  output logic [WIDTH-1:0] status_out
);
  logic [WIDTH-1:0] status_reg;
  logic [WIDTH-1:0] status_next;

  // a set in the clear cycle survives, so no event is lost
  assign status_next = (status_reg & ~clear_in) | set_in;
  assign status_out = status_reg;

  // state update
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_reg <= ptp_irq_pkg::STATUS_RESET[WIDTH-1:0];
    end else begin
      status_reg <= status_next;
    end
  end
endmodule // w1c_status

// [verification/ptp_event_interrupt_status_tb.sv]
// self-checking bench for the ptp event interrupt status block
`timescale 1ns/100ps
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  fails++; $display("ERROR %0t got %h exp %h", $time, got, exp); end end
module ptp_event_interrupt_status_tb;
  localparam logic [11:0] TSI = ptp_irq_pkg::TRIG_STATUS_IDX;
  localparam logic [11:0] TEN = ptp_irq_pkg::TRIG_ENABLE_IDX;
  localparam logic [11:0] SSI = ptp_irq_pkg::TS_STATUS_IDX;
  localparam logic [11:0] SEN = ptp_irq_pkg::TS_ENABLE_IDX;
  localparam logic [11:0] HST = ptp_irq_pkg::HOST_STATUS_IDX;
  localparam logic [11:0] HEN = ptp_irq_pkg::HOST_ENABLE_IDX;
  localparam logic [11:0] IST = ptp_irq_pkg::IRQ_STATUS_IDX;
  localparam logic [11:0] IMK = ptp_irq_pkg::IRQ_MASK_IDX;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [11:0] trig = 12'h000;
  logic [11:0] cap = 12'h000;
  logic sync_stamp = 1'b0;
  logic delay_stamp = 1'b0;
  logic trig_irq;
  logic ts_irq;
  logic irq;
  int fails = 0;
  int check_count = 0;
  logic [11:0] all_idx [8] = '{TSI, TEN, SSI, SEN, HST, HEN, IST, IMK};

  ptp_event_interrupt_status i_ptp_event_interrupt_status (
    .CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .TRIGGER_EVENT_IN(trig), .CAPTURE_UNIT_READY_IN(cap),
    .SYNC_STAMP_IN(sync_stamp), .DELAY_STAMP_IN(delay_stamp),
    .TRIGGER_HOST_IRQ_OUT(trig_irq), .TIMESTAMP_HOST_IRQ_OUT(ts_irq),
    .IRQ_OUT(irq)
  );

  // 50 mhz system clock
  initial begin
    forever #10 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one apb transfer; idle edge first so strobes never toggle twice a step
  task automatic apb(input logic wr, input logic [11:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    logic rdy;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    rdy = 1'b0;
    // values as the completing rising edge samples them
    while (rdy !== 1'b1 && n < 20) begin
      @(posedge clk);
      rdy = pready;
      rd = prdata;
      err = pslverr;
      n++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (rdy !== 1'b1) begin
      fails++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic er;
    apb(1'b1, idx, wd, rd, er);
  endtask

  task automatic chk(input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic er;
    apb(1'b0, idx, 32'h00000000, rd, er);
    `CHECK(rd, exp)
  endtask

  // one-cycle event pulse on the hardware inputs
  task automatic pulse(input logic [11:0] t, input logic [11:0] c,
                       input logic s, input logic d);
    @(posedge clk);
    trig <= t;
    cap <= c;
    sync_stamp <= s;
    delay_stamp <= d;
    @(posedge clk);
    trig <= 12'h000;
    cap <= 12'h000;
    sync_stamp <= 1'b0;
    delay_stamp <= 1'b0;
  endtask

  task automatic t_reset();
    foreach (all_idx[i]) chk(all_idx[i], 32'h00000000);
  endtask

  // status sets with enables off, zero writes keep, one writes clear
  task automatic t_trigger();
    pulse(12'h801, 12'h000, 1'b0, 1'b0);
    chk(TSI, 32'h00000801);
    chk(HST, 32'h00000400);
    @(negedge clk);
    `CHECK(trig_irq, 1'b0)
    wr(TSI, 32'h0000F7FE);
    chk(TSI, 32'h00000801);
    wr(TSI, 32'h00000001);
    chk(TSI, 32'h00000800);
    wr(TSI, 32'h00000800);
    chk(HST, 32'h00000000);
  endtask

  // reserved enable bits stay zero; a single enable bit feeds the OR
  task automatic t_enable();
    wr(TEN, 32'h0000FFFF);
    chk(TEN, 32'h00000FFF);
    wr(TEN, 32'h00000800);
    chk(HEN, 32'h00000400);
    wr(TEN, 32'h00000000);
    wr(SEN, 32'h0000FFFF);
    chk(SEN, 32'h00003FFF);
    wr(SEN, 32'h00002000);
    chk(HEN, 32'h00001000);
    wr(SEN, 32'h00000000);
    chk(HEN, 32'h00000000);
  endtask

  task automatic t_stamp();
    wr(SEN, 32'h00001000);
    pulse(12'h000, 12'h020, 1'b0, 1'b1);
    chk(SSI, 32'h00002020);
    chk(HST, 32'h00001000);
    @(negedge clk);
    `CHECK(ts_irq, 1'b1)
    chk(IST, 32'h00001000);
    wr(SSI, 32'h00002020);
    chk(SSI, 32'h00000000);
    @(negedge clk);
    `CHECK(ts_irq, 1'b0)
    pulse(12'hFFF, 12'h800, 1'b1, 1'b0);
    chk(SSI, 32'h00001800);
    wr(SSI, 32'h0000E7FF);
    chk(SSI, 32'h00001800);
    wr(SSI, 32'h00001800);
    chk(SSI, 32'h00000000);
    wr(TSI, 32'h00000FFF);
    wr(SEN, 32'h00000000);
    // the stamp group raised the sticky block bit; leave it clean
    wr(IST, 32'h00001000);
    chk(IST, 32'h00000000);
  endtask

  // sticky irq line: raise, mask, unmask, clear
  task automatic t_irq();
    wr(TEN, 32'h00000001);
    wr(IMK, 32'h00000400);
    chk(IMK, 32'h00000400);
    pulse(12'h001, 12'h000, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHECK(irq, 1'b1)
    `CHECK(trig_irq, 1'b1)
    chk(IST, 32'h00000400);
    wr(IMK, 32'h00000000);
    @(negedge clk);
    `CHECK(irq, 1'b0)
    wr(IMK, 32'h00000400);
    wr(TSI, 32'h00000001);
    wr(IST, 32'h00000400);
    @(negedge clk);
    `CHECK(irq, 1'b0)
    chk(IST, 32'h00000000);
    wr(TEN, 32'h00000000);
  endtask

  // an address past the map answers zero with an error
  task automatic t_unmapped();
    logic [31:0] rd;
    logic er;
    wr(12'h6A0, 32'h0000FFFF);
    apb(1'b0, 12'h6A0, 32'h00000000, rd, er);
    `CHECK(rd, 32'h00000000)
    `CHECK(er, 1'b1)
    apb(1'b0, TEN, 32'h00000000, rd, er);
    `CHECK(rd, 32'h00000000)
    `CHECK(er, 1'b0)
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_trigger();
    t_enable();
    t_stamp();
    t_irq();
    t_unmapped();
    complete_run();
  end
endmodule // ptp_event_interrupt_status_tb
